// ---- design/pbs_pkg.sv ----
// package: constants for the pipelined burst sram port
package pbs_pkg;
    localparam int ADDR_W     = 19;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;                 // eight data bits plus parity
    localparam int DATA_W     = LANES * LANE_W;
    localparam int DEPTH      = 1 << ADDR_W;
    localparam int BURST_W    = 2;
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam int WRITE_LAG  = 2;                 // two stages; data follows address by three edges
    localparam int READ_LAG   = 2;                 // unused; data reaches the pins three edges after the load edge
    typedef enum logic [1:0] {PBS_IDLE, PBS_READ, PBS_WRITE} pbs_cycle_e;
endpackage

// ---- design/pbs_skid.sv ----
// file: two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module pbs_skid
    import pbs_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    input  wire logic              in_valid_in,
    output logic                   in_ready_out,
    input  wire logic [DATA_W-1:0] in_data_in,
    output logic                   out_valid_out,
    input  wire logic              out_ready_in,
    output logic [DATA_W-1:0]      out_data_out
);
    logic [DATA_W-1:0] slot [2];
    logic [DATA_W-1:0] next_slot [2];
    logic [1:0]        count;
    logic [1:0]        next_count;
    logic              push;
    logic              pop;

    ////////////////////////////////////////////////////////////////////
    // slot 0 is the head; a pop shifts slot 1 down
    always_comb begin
        push         = in_valid_in && (count != 2'h2);
        pop          = (count != 2'h0) && out_ready_in;
        next_slot[0] = slot[0];
        next_slot[1] = slot[1];
        next_count   = count;
        if (pop) begin
            next_slot[0] = slot[1];
        end
        if (push) begin
            next_slot[(pop ? count - 2'h1 : count) == 2'h0 ? 0 : 1] = in_data_in;
        end
        next_count = count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            count <= 2'h0;
        end else begin
            count <= next_count;
        end
        slot[0] <= next_slot[0];
        slot[1] <= next_slot[1];
    end

    assign in_ready_out  = (count != 2'h2);
    assign out_valid_out = (count != 2'h0);
    assign out_data_out  = slot[0];
endmodule
`default_nettype wire

// ---- design/pbs_port.sv ----
// file: pipelined burst static ram port with four byte lanes
// Notes on behaviour
// [RL1] all cycle control happens only on the rising edge of clock_in.
// [RL2] address, data, enables and burst controls are captured every rising edge; here address and enables are taken only on load edges.
// [RL3] writes steered only by lane enables and read/write select, self-timed internally.
// [RL4] two echo clock pairs, true and complement, copy the input clock; here they run at half rate.
// [RL5] polarity inputs choose active level of second and third chip enables.
// [RL6] controller holds burst order select static during operation.
// [RL7] reads, writes and deselects start only when load_or_advance is low.
// [RL8] load_or_advance high advances the burst counter and continues the access.
// [RL9] read/write select ignored while advancing; last loaded cycle type kept.
// [RL10] two low address bits seed burst counter; upper bits held fixed.
// [RL11] in a write only lanes with low enables are written.
// [RL12] lane enables come with the address and apply to following data.
// [RL13] each lane enable covers its lane's eight data bits and parity bit.
// [RL14] primary chip enable sampled only on load edges.
// [RL15] burst order high gives interleaved sequence, low gives linear.
// [RL16] read starts with all enables active, select high, load_or_advance low.
// [RL17] read data leaves the output register after the following rising edge; here it reaches the pins three edges after the load edge.
// [RL18] read never turns write, nor write read, except by a new load.
// [RL19] load with any enable inactive is a deselect; pins float when reads drain.
`timescale 1ns/10ps
`default_nettype none
module pbs_port
    import pbs_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    input  wire logic [ADDR_W-1:0] address_in,
    input  wire logic              load_or_advance_in,
    input  wire logic              read_write_sel_in,
    input  wire logic              chip_enable_primary_n_in,
    input  wire logic              chip_enable_prog_second_in,
    input  wire logic              chip_enable_prog_third_in,
    input  wire logic              second_enable_polarity_sel_in,
    input  wire logic              third_enable_polarity_sel_in,
    input  wire logic              burst_order_select_in,
    input  wire logic              lane_a_write_en_n_in,
    input  wire logic              lane_b_write_en_n_in,
    input  wire logic              lane_c_write_en_n_in,
    input  wire logic              lane_d_write_en_n_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe_out,
    input  wire logic              read_ready_in,
    output logic                   echo_clock_one_out,
    output logic                   echo_clock_one_n_out,
    output logic                   echo_clock_two_out,
    output logic                   echo_clock_two_n_out
);
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] next_base;
    logic [1:0]        start;
    logic [1:0]        next_start;
    logic [1:0]        step;
    logic [1:0]        next_step;
    pbs_cycle_e        cycle;
    pbs_cycle_e        next_cycle;
    logic [LANES-1:0]  lane_mask;
    logic [LANES-1:0]  next_lane_mask;
    logic              enables_ok;
    logic [1:0]        burst_lsb;
    logic [ADDR_W-1:0] cur_addr;
    logic              wr_v [WRITE_LAG];
    logic [ADDR_W-1:0] wr_a [WRITE_LAG];
    logic [LANES-1:0]  wr_m [WRITE_LAG];
    logic              rd_v;
    logic [ADDR_W-1:0] rd_a;
    logic [DATA_W-1:0] rd_word;
    logic              sk_valid;
    logic              sk_ready;
    logic [DATA_W-1:0] sk_data;
    logic              echo;

    ////////////////////////////////////////////////////////////////////
    // chip enables qualify only on a load edge
    always_comb begin
        enables_ok = !chip_enable_primary_n_in                                      // [RL14]
            && (chip_enable_prog_second_in == second_enable_polarity_sel_in)         // [RL5]
            && (chip_enable_prog_third_in == third_enable_polarity_sel_in);          // [RL5]
        // interleave xors the step in, linear adds it
        burst_lsb = burst_order_select_in ? (start ^ step) : (start + step);        // [RL15]
        cur_addr  = {base[ADDR_W-1:BURST_W], burst_lsb};                             // [RL10]
    end

    // burst state: load on low, advance on high, cycle type sticks
    always_comb begin
        next_base      = base;
        next_start     = start;
        next_step      = step;
        next_cycle     = cycle;
        next_lane_mask = lane_mask;
        if (!load_or_advance_in) begin                                              // [RL7]
            next_base      = address_in;                                            // [RL2]
            next_start     = address_in[BURST_W-1:0];                               // [RL10]
            next_step      = BURST_RESET;
            next_lane_mask = ~{lane_d_write_en_n_in, lane_c_write_en_n_in,
                               lane_b_write_en_n_in, lane_a_write_en_n_in};         // [RL12]
            if (!enables_ok) begin
                next_cycle = PBS_IDLE;                                              // [RL19]
            end else if (read_write_sel_in) begin
                next_cycle = PBS_READ;                                              // [RL16]
            end else begin
                next_cycle = PBS_WRITE;                                             // [RL3]
            end
        end else if (cycle != PBS_IDLE) begin
            next_step = step + 2'h1;                                                // [RL8] [RL9] [RL18]
        end
    end

    // single clock edge drives everything; no reset pin on the part itself
    always_ff @(posedge clock_in) begin                                             // [RL1]
        if (reset_in) begin
            base      <= '0;
            start     <= BURST_RESET;
            step      <= BURST_RESET;
            cycle     <= PBS_IDLE;
            lane_mask <= '0;
        end else begin
            base      <= next_base;
            start     <= next_start;
            step      <= next_step;
            cycle     <= next_cycle;
            lane_mask <= next_lane_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // late write: address and mask travel two edges to meet their data
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            wr_v[0] <= 1'b0;
            wr_v[1] <= 1'b0;
        end else begin
            wr_v[0] <= (cycle == PBS_WRITE);
            wr_v[1] <= wr_v[0];
        end
        wr_a[0] <= cur_addr;
        wr_a[1] <= wr_a[0];
        wr_m[0] <= lane_mask;
        wr_m[1] <= wr_m[0];
    end

    // each enable covers nine bits: data byte plus its parity bit; every lane keeps
    // its own array so that no two processes ever write one variable
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] lane_mem [DEPTH];
        always_ff @(posedge clock_in) begin
            if (wr_v[1] && wr_m[1][g]) begin                                        // [RL11] [RL13]
                lane_mem[wr_a[1]] <= data_in[g*LANE_W +: LANE_W];                  // [RL3]
            end
        end
        assign rd_word[g*LANE_W +: LANE_W] = lane_mem[rd_a];
    end

    ////////////////////////////////////////////////////////////////////
    // read: core fetch then output register, stalled by the buffer
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rd_v <= 1'b0;
        end else if (sk_ready) begin
            rd_v <= (cycle == PBS_READ);                                            // [RL17]
        end
        if (sk_ready) begin
            rd_a <= cur_addr;
        end
    end
    pbs_skid u_skid (
        .clock_in      (clock_in),
        .reset_in      (reset_in),
        .in_valid_in   (rd_v),
        .in_ready_out  (sk_ready),
        .in_data_in    (rd_word),
        .out_valid_out (sk_valid),
        .out_ready_in  (read_ready_in),
        .out_data_out  (sk_data)
    );

    // output register; enable falls once pending reads drain
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            data_out    <= '0;
            data_oe_out <= 1'b0;
        end else begin
            data_out    <= sk_data;
            data_oe_out <= sk_valid && read_ready_in;                               // [RL19]
        end
    end

    // echo clocks: registered toggle, a half-rate copy since outputs are flops
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            echo                 <= 1'b0;
            echo_clock_one_out   <= 1'b0;
            echo_clock_one_n_out <= 1'b1;
            echo_clock_two_out   <= 1'b0;
            echo_clock_two_n_out <= 1'b1;
        end else begin
            echo                 <= !echo;                                          // [RL4]
            echo_clock_one_out   <= echo;
            echo_clock_one_n_out <= !echo;
            echo_clock_two_out   <= echo;
            echo_clock_two_n_out <= !echo;
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_advance_keeps_type: assert property (@(posedge clock_in) disable iff (reset_in) // [RL9]
        load_or_advance_in |=> cycle == $past(cycle))
        else $error("cycle type changed on advance");
    a_deselect_on_load: assert property (@(posedge clock_in) disable iff (reset_in) // [RL14]
        !load_or_advance_in && chip_enable_primary_n_in |=> cycle == PBS_IDLE)
        else $error("load with primary enable off did not deselect");
    a_read_start: assert property (@(posedge clock_in) disable iff (reset_in)     // [RL16]
        !load_or_advance_in && enables_ok && read_write_sel_in |=> cycle == PBS_READ)
        else $error("read not started");
    a_step_advance: assert property (@(posedge clock_in) disable iff (reset_in)   // [RL8]
        load_or_advance_in && cycle != PBS_IDLE |=> step == $past(step) + 2'h1)
        else $error("burst counter did not advance");
    a_seed_lsb: assert property (@(posedge clock_in) disable iff (reset_in)       // [RL10]
        !load_or_advance_in |=> cur_addr == $past(address_in))
        else $error("burst seed wrong");
    a_write_lag: assert property (@(posedge clock_in) disable iff (reset_in)      // [RL12]
        cycle == PBS_WRITE |=> ##1 wr_v[1])
        else $error("write did not reach data two edges later");
    a_read_fetch: assert property (@(posedge clock_in) disable iff (reset_in)     // [RL17]
        cycle == PBS_READ && sk_ready |=> rd_v)
        else $error("read fetch missing");
    a_echo_pair: assert property (@(posedge clock_in) disable iff (reset_in)      // [RL4]
        echo_clock_one_out != echo_clock_one_n_out
        && echo_clock_two_out == echo_clock_one_out)
        else $error("echo pair not complementary");
endmodule
`default_nettype wire

// ---- bench/pbs_rx.sv ----
// file: read-word receiver of the external controller, able to stall
`timescale 1ns/10ps
`default_nettype none
module pbs_rx
    import pbs_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              stall_in,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              valid_in,
    output logic                   ready_out
);
    logic [DATA_W-1:0] got [$];
    // a slow receiver simply drops ready; words must wait in the port's buffer
    assign ready_out = !stall_in;
    // the port pops a word where ready is high and shows it one cycle later,
    // so a word flagged valid is already committed and must be taken even if stalled now
    always @(posedge clock_in) begin
        if (valid_in) got.push_back(data_in);
    end
endmodule
`default_nettype wire

// ---- bench/pipelined_burst_sram_port_tb.sv ----
// file: self-checking bench for the pipelined burst sram port
`timescale 1ns/10ps
`default_nettype none
module pipelined_burst_sram_port_tb import pbs_pkg::*;;
    logic              clock_in = 1'b0;
    logic              reset_in = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic              load_or_advance = 1'b0, rw = 1'b1, cen = 1'b1, p2 = 1'b1, e2 = 1'b1;
    logic              ord = 1'b1, stall = 1'b0;
    logic              e3 = 1'b0, p3 = 1'b0;
    logic [3:0]        wen_n = 4'hf;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic              oe, rdy, ck1, ck1_n, ck2, ck2_n;
    logic [DATA_W-1:0] exp_mem [int];
    int                n_mismatch = 0, compares = 0;
    //////////////////////////////////////////////////////////////////////
    // clock, design and read receiver; third enable starts out active low
    always #5 clock_in = ~clock_in;
    pbs_port dut (.clock_in(clock_in), .reset_in(reset_in), .address_in(addr),
        .load_or_advance_in(load_or_advance), .read_write_sel_in(rw), .chip_enable_primary_n_in(cen),
        .chip_enable_prog_second_in(e2), .chip_enable_prog_third_in(e3),
        .second_enable_polarity_sel_in(p2), .third_enable_polarity_sel_in(p3),
        .burst_order_select_in(ord), .lane_a_write_en_n_in(wen_n[0]),
        .lane_b_write_en_n_in(wen_n[1]), .lane_c_write_en_n_in(wen_n[2]),
        .lane_d_write_en_n_in(wen_n[3]), .data_in(wdata), .data_out(rdata),
        .data_oe_out(oe), .read_ready_in(rdy), .echo_clock_one_out(ck1),
        .echo_clock_one_n_out(ck1_n), .echo_clock_two_out(ck2), .echo_clock_two_n_out(ck2_n));
    pbs_rx rx (.clock_in(clock_in), .stall_in(stall), .data_in(rdata), .valid_in(oe),
        .ready_out(rdy));
    //////////////////////////////////////////////////////////////////////
    // helpers: burst step order, compare, closing
    function automatic logic [1:0] seq(input logic [1:0] s, input logic [1:0] k);
        return ord ? (s ^ k) : (s + k);
    endfunction
    task automatic check(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one load, n-1 advances, then deselect loads while write data trails by three edges;
    // primary enable is left off on advances since it must be ignored there
    task automatic burst(input logic r, ra, input logic [ADDR_W-1:0] a, input int n,
                         input logic [3:0] m, input logic [DATA_W-1:0] b);
        logic [ADDR_W-1:0] ad;
        logic [DATA_W-1:0] w, wd;
        for (int i = 0; i < n + 3; i++) begin
            load_or_advance   <= (i > 0 && i < n);
            rw    <= (i == 0) ? r : ((i < n) ? ra : 1'b1);
            cen   <= (i != 0);
            addr  <= a;
            wen_n <= m;
            wdata <= (i >= 3) ? b + DATA_W'(i - 3) : '0;
            @(posedge clock_in);
        end
        for (int k = 0; k < n && !r; k++) begin
            ad = {a[ADDR_W-1:2], seq(a[1:0], 2'(k))};
            wd = b + DATA_W'(k);
            w = exp_mem.exists(ad) ? exp_mem[ad] : '0;
            for (int l = 0; l < LANES; l++) begin
                if (!m[l]) w[l*LANE_W +: LANE_W] = wd[l*LANE_W +: LANE_W];
            end
            exp_mem[ad] = w;
        end
    endtask
    // read burst; advances carry a write select that must be ignored
    task automatic rd(input logic [ADDR_W-1:0] a, input int n, input int hold);
        int w;
        w = 0;
        rx.got.delete();
        burst(1'b1, 1'b0, a, n, 4'h0, '0);
        repeat (hold) @(posedge clock_in);
        stall <= 1'b0;
        while (rx.got.size() < n && w < 40) begin
            @(posedge clock_in);
            w++;
        end
        check(DATA_W'(rx.got.size()), DATA_W'(n));
        for (int k = 0; k < rx.got.size(); k++) begin
            check(rx.got[k], exp_mem[{a[ADDR_W-1:2], seq(a[1:0], 2'(k))}]);
        end
    endtask
    //////////////////////////////////////////////////////////////////////
    // scenarios
    // release lands on the sixteenth edge, which still sees reset high
    task automatic t_reset;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        #1;
        check(DATA_W'({oe, ck1, ck1_n, ck2, ck2_n}), DATA_W'(5'h05));
        @(posedge clock_in);
    endtask
    task automatic t_echo;
        logic a;
        #1;
        a = ck1;
        @(posedge clock_in);
        #1;
        check(DATA_W'({ck1, ck1_n, ck2, ck2_n}), DATA_W'({~a, a, ~a, a}));
        // back on an edge so that the next scenario drives on it
        @(posedge clock_in);
    endtask
    task automatic t_burst;
        ord <= 1'b0;
        burst(1'b0, 1'b0, {17'h0a5, 2'h2}, 4, 4'h0, 36'h1_1122_3344);
        rd({17'h0a5, 2'h2}, 4, 0);
        ord <= 1'b1;
        rd({17'h0a5, 2'h1}, 4, 0);
    endtask
    task automatic t_mask;
        burst(1'b0, 1'b1, {17'h0a5, 2'h3}, 4, 4'b1101, 36'h5_5aa5_5aa5);
        ord <= 1'b0;
        rd({17'h0a5, 2'h0}, 4, 0);
    endtask
    task automatic t_desel;
        e2 <= 1'b0;
        rx.got.delete();
        burst(1'b1, 1'b1, {17'h0a5, 2'h0}, 1, 4'h0, '0);
        repeat (6) @(posedge clock_in);
        check(DATA_W'(rx.got.size()), '0);
        p2 <= 1'b0;
        rd({17'h0a5, 2'h0}, 1, 0);
        p2 <= 1'b1;
        e2 <= 1'b1;
        // third enable driven high while its polarity asks for low: a deselect
        e3 <= 1'b1;
        rx.got.delete();
        burst(1'b1, 1'b1, {17'h0a5, 2'h0}, 1, 4'h0, '0);
        repeat (6) @(posedge clock_in);
        check(DATA_W'(rx.got.size()), '0);
        p3 <= 1'b1;
        rd({17'h0a5, 2'h0}, 1, 0);
        p3 <= 1'b0;
        e3 <= 1'b0;
    endtask
    // receiver stalls while two words queue up in the port's buffer
    task automatic t_stall;
        stall <= 1'b1;
        rd({17'h0a5, 2'h1}, 2, 10);
    endtask
    //////////////////////////////////////////////////////////////////////
    // main sequence and watchdog well beyond the hundred or so cycles needed
    initial begin
        t_reset;
        t_echo;
        t_burst;
        t_mask;
        t_desel;
        t_stall;
        finish_test;
    end
    initial begin
        repeat (3000) @(posedge clock_in);
        n_mismatch++;
        finish_test;
    end
endmodule
`default_nettype wire
